// ===== bench/fprm_host_model.sv
`timescale 1ns/1ps
// Host side of the open-drain reset line, with its pull-up
module fprm_host_model (
   // Clock
   input  wire logic        clk,
   // Open-drain driver of the block
   input  wire logic        rstOut,
   input  wire logic        rstOutOe,
   // Line as the host sees it
   output logic             resetLine,
   output logic             pulseEnd,
   output logic      [31:0] lowLen
);
   logic [31:0] lowCnt_r = 32'h0;

   // A released line goes to the pull-up level, never to the last value
   assign resetLine = rstOutOe ? rstOut : 1'b1;

   // Length of every low period, reported as it ends
   always_ff @(posedge clk) begin
      pulseEnd <= 1'b0;
      if (resetLine == 1'b0) begin
         lowCnt_r <= lowCnt_r + 32'h1;
      end else if (lowCnt_r != 32'h0) begin
         lowLen   <= lowCnt_r;
         pulseEnd <= 1'b1;
         lowCnt_r <= 32'h0;
      end
   end
endmodule : fprm_host_model

// ===== bench/test_fprm_fault_mgr.sv
`timescale 1ns/1ps
`include "fprm_map.svh"
module test_fprm_fault_mgr;
   import fprm_pkg::*;
   // Short counts keep the run brief
   localparam int PULSE  = 20;
   localparam int PORRST = 50;
   localparam int GAP    = 5;
   logic        clk;
   logic        rst_n;
   logic [7:0]  avsAddress;
   logic        avsRead;
   logic        avsWrite;
   logic [31:0] avsWritedata;
   logic [31:0] avsReaddata;
   logic        avsWaitrequest;
   logic [2:0]  vdFault;
   logic        ocFault;
   logic        otFault;
   logic        sleepIn;
   logic [1:0]  convSelect;
   logic [2:0]  convEnable;
   logic        motorEnable;
   logic [15:0] motorLatch;
   logic        rstOut;
   logic        rstOutOe;
   logic        irq;
   logic        resetLine;
   logic        pulseEnd;
   logic [31:0] lowLen;
   int          errors;
   int          total_checks;
   int          seed;
   logic [31:0] rnd;
   logic [31:0] rdQ[$];
   string       nmQ[$];
   logic [31:0] pulseQ[$];

   fprm_fault_mgr #(.PULSE_CYC(PULSE), .PORRST_CYC(PORRST), .SEQ_GAP_CYC(GAP)) dut (
      .clk(clk), .rst_n(rst_n), .avs_address(avsAddress), .avs_read(avsRead),
      .avs_write(avsWrite), .avs_writedata(avsWritedata), .avs_readdata(avsReaddata),
      .avs_waitrequest(avsWaitrequest), .voltageDropFault(vdFault),
      .overcurrentFault(ocFault), .overtempFault(otFault), .sleepIn(sleepIn),
      .convSelect(convSelect), .convEnable(convEnable), .motorEnable(motorEnable),
      .motorLatch(motorLatch), .systemResetOut_o(rstOut), .systemResetOut_oe(rstOutOe),
      .irq(irq));

   fprm_host_model host (.clk(clk), .rstOut(rstOut), .rstOutOe(rstOutOe),
      .resetLine(resetLine), .pulseEnd(pulseEnd), .lowLen(lowLen));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic test_done;
      if (errors == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : test_done

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   // Request held until the edge that sees waitrequest low
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      avsAddress   <= a;
      avsWritedata <= d;
      avsWrite     <= wr;
      avsRead      <= ~wr;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (avsWaitrequest !== 1'b0 && n < 20);
      if (n >= 20) begin
         errors++;
         $display("[FAIL] waitrequest expected 0 seen 1");
      end
      avsRead  <= 1'b0;
      avsWrite <= 1'b0;
   endtask : bus

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      rdQ.push_back(e);
      nmQ.push_back(nm);
      bus(1'b0, a, 32'h0);
   endtask : rd

   task automatic sl(input logic v);
      sleepIn <= v;
      cyc(10);
   endtask : sl

   // Fault levels held for n cycles, then dropped and given time to settle
   task automatic flt(input logic [2:0] vd, input logic oc, input logic ot, input int n);
      vdFault <= vd;
      ocFault <= oc;
      otFault <= ot;
      cyc(n);
      vdFault <= 3'h0;
      ocFault <= 1'b0;
      otFault <= 1'b0;
      cyc(10);
   endtask : flt

   task automatic powerUp(input logic [1:0] sel, input logic [2:0] first, input logic [2:0] both);
      int n;
      rst_n      <= 1'b0;
      convSelect <= sel;
      sleepIn    <= 1'b0;
      cyc(5);
      chk("reset line in reset", resetLine, 32'h0);
      chk("enables in reset", {motorEnable, convEnable}, 32'h0);
      rst_n <= 1'b1;
      n = 0;
      while (convEnable === 3'h0 && n < 20) begin
         cyc(1);
         n++;
      end
      chk("first converter", convEnable, first);
      while (convEnable === first && n < 40) begin
         cyc(1);
         n++;
      end
      chk("both converters", convEnable, both);
      cyc(45 - n);
      chk("power-up hold", resetLine, 32'h0);
      cyc(15);
      chk("reset line idle", resetLine, 32'h1);
   endtask : powerUp

   always @(posedge clk) begin
      if (avsRead && avsWaitrequest === 1'b0 && rdQ.size() > 0) begin
         chk(nmQ.pop_front(), avsReaddata, rdQ.pop_front());
      end
      if (pulseEnd === 1'b1 && pulseQ.size() > 0) begin
         chk("pulse length", lowLen, pulseQ.pop_front());
      end
   end

   initial begin
      seed = 32'h7b26;
      errors = 0;
      total_checks = 0;
      rst_n = 1'b0;
      avsAddress = 8'h0;
      avsRead = 1'b0;
      avsWrite = 1'b0;
      avsWritedata = 32'h0;
      vdFault = 3'h0;
      ocFault = 1'b0;
      otFault = 1'b0;
      sleepIn = 1'b0;
      convSelect = 2'h1;
      powerUp(2'h2, 3'h2, 3'h6);
      powerUp(2'h0, 3'h0, 3'h0);
      powerUp(2'h1, 3'h2, 3'h3);
      rd(`FPRM_ADDR_CTRL, 32'h1, "ctrl reset");
      rd(`FPRM_ADDR_STATUS, 32'h243, "status");
      rd(8'h14, 32'h0, "unmapped");
      bus(1'b1, 8'h14, 32'hffffffff);
      for (int i = 0; i < 3; i++) begin
         rnd = $random(seed);
         bus(1'b1, `FPRM_ADDR_INTMASK, rnd);
         rd(`FPRM_ADDR_INTMASK, {26'h0, rnd[5:0]}, "intmask");
      end
      bus(1'b1, `FPRM_ADDR_INTMASK, 32'h0);
      bus(1'b1, `FPRM_ADDR_INTSTAT, 32'h3f);
      flt(3'h1, 1'b1, 1'b0, 150);
      chk("short faults", {resetLine, convEnable}, 32'hb);
      flt(3'h1, 1'b0, 1'b0, 620);
      chk("drop A", convEnable, 32'h2);
      chk("drop A reset", resetLine, 32'h1);
      rd(`FPRM_ADDR_INTSTAT, 32'h1, "intstat");
      chk("irq masked", irq, 32'h0);
      bus(1'b1, `FPRM_ADDR_INTMASK, 32'h1);
      cyc(3);
      chk("irq", irq, 32'h1);
      bus(1'b1, `FPRM_ADDR_INTSTAT, 32'h1);
      cyc(3);
      chk("irq cleared", irq, 32'h0);
      sl(1'b1);
      chk("restart A", {motorEnable, convEnable}, 32'hb);
      flt(3'h2, 1'b0, 1'b0, 620);
      chk("drop B", convEnable, 32'h1);
      sl(1'b0);
      chk("B still off", convEnable, 32'h1);
      rnd = $random(seed);
      bus(1'b1, `FPRM_ADDR_LATCH, {16'h0, rnd[15:0] | 16'h0001});
      rd(`FPRM_ADDR_LATCH, {16'h0, rnd[15:0] | 16'h0001}, "latch data");
      sl(1'b1);
      chk("restart B", convEnable, 32'h3);
      chk("latch cleared", motorLatch, 32'h0);
      bus(1'b1, `FPRM_ADDR_LATCH, 32'h0000_a5c3);
      rd(`FPRM_ADDR_LATCH, 32'h0000_a5c3, "latch set");
      pulseQ.push_back(PULSE);
      ocFault <= 1'b1;
      cyc(210);
      chk("trip pulse", resetLine, 32'h0);
      flt(3'h0, 1'b1, 1'b0, 10);
      chk("motor trip", {motorEnable, convEnable}, 32'h3);
      chk("motor data", motorLatch, 32'h0);
      cyc(30);
      sl(1'b0);
      sl(1'b1);
      chk("motor restart", {resetLine, motorEnable}, 32'h3);
      bus(1'b1, `FPRM_ADDR_CTRL, 32'h0);
      flt(3'h0, 1'b1, 1'b0, 220);
      chk("mask 0 trip", {resetLine, motorEnable}, 32'h2);
      bus(1'b1, `FPRM_ADDR_CTRL, 32'h1);
      flt(3'h0, 1'b0, 1'b1, 620);
      chk("thermal stop", {resetLine, motorEnable, convEnable}, 32'h0);
      sl(1'b0);
      flt(3'h1, 1'b1, 1'b0, 620);
      sl(1'b1);
      chk("thermal held", {resetLine, motorEnable, convEnable}, 32'h0);
      powerUp(2'h1, 3'h2, 3'h3);
      chk("pulses seen", pulseQ.size(), 32'h0);
      test_done();
   end

   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      test_done();
   end
endmodule : test_fprm_fault_mgr

// ===== hdl/fprm_fault_mgr.sv
// Local design decisions: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`include "fprm_map.svh"

module fprm_fault_mgr
   import fprm_pkg::*;
#(
   parameter int       PULSE_CYC   = `FPRM_PULSE_MS * (`FPRM_CLK_HZ / 1000),
   parameter int       PORRST_CYC  = `FPRM_PORRST_MS * (`FPRM_CLK_HZ / 1000),
   parameter int       SEQ_GAP_CYC = `FPRM_SEQ_GAP_US * (`FPRM_CLK_HZ / 1000000),
   parameter bit       MASK0_PULSE = 1'b0
)(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Avalon-MM slave
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // Fault detector and control pins
   input  wire logic [2:0]  voltageDropFault,
   input  wire logic        overcurrentFault,
   input  wire logic        overtempFault,
   input  wire logic        sleepIn,
   input  wire logic [1:0]  convSelect,
   // Block enables and motor data
   output logic      [2:0]  convEnable,
   output logic             motorEnable,
   output logic      [15:0] motorLatch,
   // Open-drain reset toward the host system
   output logic             systemResetOut_o,
   output logic             systemResetOut_oe,
   // Interrupt
   output logic             irq
);

   localparam int VD_CYC = (`FPRM_VD_MASK_REF * `FPRM_CLK_HZ + `FPRM_REF_HZ - 1) / `FPRM_REF_HZ;
   localparam int OT_CYC = (`FPRM_OT_MASK_REF * `FPRM_CLK_HZ + `FPRM_REF_HZ - 1) / `FPRM_REF_HZ;
   localparam int OC_CYC = (`FPRM_OC_MASK_REF * `FPRM_CLK_HZ + `FPRM_REF_HZ - 1) / `FPRM_REF_HZ;
   localparam int PW     = $clog2(PULSE_CYC + 1);
   localparam int RW     = $clog2(PORRST_CYC + 1);
   localparam int SW     = $clog2(SEQ_GAP_CYC + 1);

   if (PULSE_CYC < 1 || PORRST_CYC < 1 || SEQ_GAP_CYC < 1 || PORRST_CYC >= 2**30) begin : g_chk
      $error("fprm_fault_mgr: timing parameters out of range");
   end

   logic [7:0]      syn1_r, syn2_r, syn3_r, lvl_r;
   logic            sleepPrev_r, sleepRise, sleepFall;
   logic [9:0]      fltCnt_r [5];
   logic [9:0]      fltLim [5];
   logic [4:0]      fltHit;
   fprm_evt_t       evt, intStat_r, intMask_r;
   logic [2:0]      convStop_r, convNeedFall_r, convStarted_r, convSelMask_r;
   logic            motorStop_r, motorNeedFall_r, otLatch_r;
   logic [15:0]     motorLatch_r;
   fprm_pwr_state_t psState_r;
   logic [2:0]      settle_r;
   logic [SW-1:0]   seqCnt_r;
   logic [RW-1:0]   porCnt_r;
   logic            porDone, porHit;
   logic [PW-1:0]   pulseCnt_r;
   logic            ctrlMask_r, rstLow, rstOe_r;
   logic            ack_r, wrEn;
   logic [31:0]     rdData_r;

   function automatic logic [9:0] filtStep(input logic [9:0] cnt, input logic lvl,
                                           input logic [9:0] lim);
      if (!lvl)
         return 10'h000;
      else if (cnt < lim)
         return cnt + 10'h001;
      else
         return cnt;
   endfunction : filtStep

   // Pin synchroniser; a level changes only once stages two and three agree
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         syn1_r <= 8'h00;
         syn2_r <= 8'h00;
         syn3_r <= 8'h00;
         lvl_r  <= 8'h00;
      end else begin
         syn1_r <= {convSelect, sleepIn, overtempFault, overcurrentFault, voltageDropFault};
         syn2_r <= syn1_r;
         syn3_r <= syn2_r;
         lvl_r  <= (syn2_r & syn3_r) | (lvl_r & (syn2_r ^ syn3_r));
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         sleepPrev_r <= 1'b0;
      else
         sleepPrev_r <= lvl_r[5];
   end

   assign sleepRise = lvl_r[5] & ~sleepPrev_r;
   assign sleepFall = ~lvl_r[5] & sleepPrev_r;

   // Deglitch windows; fault index 0..2 voltage drop A..C, 3 overcurrent, 4 overtemp
   assign fltLim[0] = 10'(VD_CYC);
   assign fltLim[1] = 10'(VD_CYC);
   assign fltLim[2] = 10'(VD_CYC);
   assign fltLim[3] = 10'(OC_CYC);
   assign fltLim[4] = 10'(OT_CYC);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 5; i++)
            fltCnt_r[i] <= 10'h000;
      end else begin
         for (int i = 0; i < 5; i++)
            fltCnt_r[i] <= filtStep(fltCnt_r[i], lvl_r[i], fltLim[i]);
      end
   end

   // One-shot on acceptance; the counter parks at its limit while the fault stays
   always_comb begin
      for (int i = 0; i < 5; i++)
         fltHit[i] = lvl_r[i] && (fltCnt_r[i] == fltLim[i] - 10'h001);
   end
   // Per-converter stop and restart tracking
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         convStop_r     <= 3'h0;
         convNeedFall_r <= 3'h0;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (fltHit[i]) begin
               convStop_r[i]     <= 1'b1;
               convNeedFall_r[i] <= lvl_r[5];
            end else if (convStop_r[i]) begin
               if (sleepFall)
                  convNeedFall_r[i] <= 1'b0;
               else if (sleepRise && !convNeedFall_r[i])
                  convStop_r[i] <= 1'b0;
            end
         end
      end
   end

   // Motor stop always needs a fresh fall then rise of sleep
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         motorStop_r     <= 1'b0;
         motorNeedFall_r <= 1'b0;
      end else if (fltHit[3]) begin
         motorStop_r     <= 1'b1;
         motorNeedFall_r <= 1'b1;
      end else if (motorStop_r && sleepFall) begin
         motorNeedFall_r <= 1'b0;
      end else if (motorStop_r && sleepRise && !motorNeedFall_r) begin
         motorStop_r <= 1'b0;
      end
   end
   // Only power-on reset clears the thermal latch
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         otLatch_r <= 1'b0;
      else if (fltHit[4])
         otLatch_r <= 1'b1;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         motorLatch_r <= 16'h0000;
      else if (sleepRise || sleepFall || fltHit[3])
         motorLatch_r <= 16'h0000;
      else if (wrEn && avs_address == `FPRM_ADDR_LATCH)
         motorLatch_r <= avs_writedata[15:0];
   end

   // Power-up sequencing; select is taken once the synchroniser has settled
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         psState_r     <= PS_SETTLE;
         settle_r      <= 3'h0;
         seqCnt_r      <= '0;
         convSelMask_r <= 3'h0;
         convStarted_r <= 3'h0;
      end else begin
         case (psState_r)
            PS_SETTLE: begin
               settle_r <= settle_r + 3'h1;
               if (settle_r == 3'h4) begin
                  case (lvl_r[7:6])
                     2'h0:    convSelMask_r <= 3'h0;
                     2'h1:    convSelMask_r <= 3'h3;
                     default: convSelMask_r <= 3'h6;
                  endcase
                  psState_r <= (lvl_r[7:6] == 2'h0) ? PS_RUN : PS_FIRST;
               end
            end
            PS_FIRST: begin
               convStarted_r <= 3'h2;
               seqCnt_r      <= seqCnt_r + SW'(1);
               if (seqCnt_r == SW'(SEQ_GAP_CYC - 1))
                  psState_r <= PS_SECOND;
            end
            PS_SECOND: begin
               convStarted_r <= convSelMask_r;
               psState_r     <= PS_RUN;
            end
            PS_RUN:  convStarted_r <= convSelMask_r;
            default: psState_r <= PS_SETTLE;
         endcase
      end
   end

   // Power-on reset hold time counter
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         porCnt_r <= '0;
      else if (!porDone)
         porCnt_r <= porCnt_r + RW'(1);
   end
   assign porDone = (porCnt_r == RW'(PORRST_CYC));
   assign porHit  = (porCnt_r == RW'(PORRST_CYC - 1));
   // Motor-fault reset pulse; mask 0 pulses only if the option is set
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         pulseCnt_r <= '0;
      else if (fltHit[3] && (ctrlMask_r || MASK0_PULSE))
         pulseCnt_r <= PW'(PULSE_CYC);
      else if (pulseCnt_r != '0)
         pulseCnt_r <= pulseCnt_r - PW'(1);
   end
   assign rstLow = otLatch_r || !porDone || (pulseCnt_r != '0);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         rstOe_r <= 1'b1;
      else
         rstOe_r <= rstLow;
   end
   assign systemResetOut_o  = 1'b0;
   assign systemResetOut_oe = rstOe_r;
   assign convEnable  = convStarted_r & ~convStop_r & {3{~otLatch_r}};
   assign motorEnable = lvl_r[5] & ~motorStop_r & ~otLatch_r;
   assign motorLatch  = motorLatch_r;
   // Sticky interrupt status, write one to clear; a new event beats the clear
   assign evt = '{pwrDone: porHit, overTemp: fltHit[4], overCur: fltHit[3],
                  voltDrop: fltHit[2:0]};
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         intStat_r <= '0;
         intMask_r <= '0;
      end else begin
         if (wrEn && avs_address == `FPRM_ADDR_INTSTAT)
            intStat_r <= (intStat_r & ~avs_writedata[`FPRM_EVT_WIDTH-1:0]) | evt;
         else
            intStat_r <= intStat_r | evt;
         if (wrEn && avs_address == `FPRM_ADDR_INTMASK)
            intMask_r <= avs_writedata[`FPRM_EVT_WIDTH-1:0];
      end
   end
   assign irq = |(intStat_r & intMask_r);
   // Bus slave: one wait cycle, so data and writes land on the second edge
   assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
   assign wrEn            = avs_write && ack_r;
   assign avs_readdata    = rdData_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_r      <= 1'b0;
         rdData_r   <= 32'h0000_0000;
         ctrlMask_r <= `FPRM_CTRL_RESET;
      end else begin
         ack_r <= (avs_read || avs_write) && !ack_r;
         if (avs_read && !ack_r) begin
            case (avs_address)
               `FPRM_ADDR_CTRL:    rdData_r <= {31'h0, ctrlMask_r};
               `FPRM_ADDR_STATUS:  rdData_r <= {22'h0, convSelMask_r[0], convSelMask_r[2],
                                                lvl_r[5], porDone, rstLow, otLatch_r,
                                                motorEnable, convEnable};
               `FPRM_ADDR_INTSTAT: rdData_r <= {26'h0, intStat_r};
               `FPRM_ADDR_INTMASK: rdData_r <= {26'h0, intMask_r};
               `FPRM_ADDR_LATCH:   rdData_r <= {16'h0, motorLatch_r};
               default:            rdData_r <= 32'h0000_0000;
            endcase
         end
         if (wrEn && avs_address == `FPRM_ADDR_CTRL)
            ctrlMask_r <= avs_writedata[`FPRM_CTRL_MASK_BIT];
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence sMotorTrip;
      ##1 (motorStop_r && motorNeedFall_r && motorLatch_r == 16'h0000);
   endsequence
   a_idle_rst_high: assert property (porDone && !otLatch_r && pulseCnt_r == '0
      && !fltHit[3] |=> !systemResetOut_oe) else $error("reset out low with no fault");
   a_vd_stop_one: assert property (fltHit[1] && !fltHit[4] && !otLatch_r
      |=> !convEnable[1] && !otLatch_r) else $error("converter B not stopped");
   a_vd_low_restart: assert property (convStop_r[0] && !convNeedFall_r[0]
      && sleepRise && !fltHit[0] |=> !convStop_r[0]) else $error("converter A not restarted");
   a_vd_high_wait: assert property (fltHit[1] && lvl_r[5]
      |=> convStop_r[1] && convNeedFall_r[1]) else $error("restart armed too early");
   a_motor_trip: assert property (fltHit[3] |-> sMotorTrip)
      else $error("motor trip incomplete");
   a_oc_pulse_len: assert property (fltHit[3] && ctrlMask_r
      |=> pulseCnt_r == PW'(PULSE_CYC) ##1 systemResetOut_oe)
      else $error("reset pulse wrong");
   a_ot_shutdown: assert property (otLatch_r |-> convEnable == 3'h0 && !motorEnable
      ##1 systemResetOut_oe) else $error("thermal shutdown incomplete");
   a_oc_filter: assert property (fltHit[3] |-> $past(lvl_r[3])
      && fltCnt_r[3] == 10'(OC_CYC - 1)) else $error("overcurrent taken early");
   a_seq_b_first: assert property (!convStarted_r[1] |-> convStarted_r == 3'h0)
      else $error("channel B not first");
   a_por_hold: assert property (!porDone |=> systemResetOut_oe)
      else $error("reset released early");
   a_csel_map: assert property (psState_r == PS_RUN && $past(psState_r == PS_RUN)
      |-> convStarted_r == convSelMask_r) else $error("wrong converter set");
   a_latch_clear: assert property (sleepRise || sleepFall || fltHit[3]
      |=> motorLatch_r == 16'h0000) else $error("motor latch not cleared");
   a_ot_sticky: assert property (otLatch_r |=> otLatch_r)
      else $error("thermal latch lost");

endmodule : fprm_fault_mgr

// ===== hdl/fprm_map.svh
`ifndef FPRM_MAP_SVH
`define FPRM_MAP_SVH

// Clock rates
`define FPRM_CLK_HZ        40000000
`define FPRM_REF_HZ        800000

// Fault mask windows, in reference-clock cycles (shortest accepted figure)
`define FPRM_VD_MASK_REF   12
`define FPRM_OT_MASK_REF   12
`define FPRM_OC_MASK_REF   4

// Times
`define FPRM_PULSE_MS      40
`define FPRM_PORRST_MS     320
`define FPRM_SEQ_GAP_US    1000

// Register byte addresses
`define FPRM_ADDR_CTRL     8'h00
`define FPRM_ADDR_STATUS   8'h04
`define FPRM_ADDR_INTSTAT  8'h08
`define FPRM_ADDR_INTMASK  8'h0c
`define FPRM_ADDR_LATCH    8'h10

// Field positions and reset values
`define FPRM_CTRL_MASK_BIT 0
`define FPRM_CTRL_RESET    1'h1
`define FPRM_EVT_WIDTH     6

`endif

// ===== hdl/fprm_pkg.sv
package fprm_pkg;

   typedef enum logic [1:0] {
      PS_SETTLE = 2'h0,
      PS_FIRST  = 2'h1,
      PS_SECOND = 2'h3,
      PS_RUN    = 2'h2
   } fprm_pwr_state_t;

   typedef struct packed {
      logic       pwrDone;
      logic       overTemp;
      logic       overCur;
      logic [2:0] voltDrop;
   } fprm_evt_t;

endpackage : fprm_pkg
